//--- sleep_ctl_pkg.sv
package sleep_ctl_pkg;

  localparam logic [12:0] IRQ_VECTOR_ADDR = 13'h0004;
  localparam logic [12:0] PC_STEP         = 13'h0001;
  localparam int          PD_BIT          = 3;
  localparam int          TO_BIT          = 4;
  localparam logic        PD_RESET_VAL    = 1'b1;
  localparam logic        TO_RESET_VAL    = 1'b1;
  localparam int          OSC_RESTART_NS  = 100;
  localparam int          CLK_PERIOD_NS   = 50;
  localparam logic [3:0]  OSC_RESTART_CYC =
    4'((OSC_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          NUM_PERIPH_SRC  = 12;
  localparam int          NUM_PINS        = 8;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_ENTER   = 3'b001,
    ST_ASLEEP  = 3'b010,
    ST_RESTART = 3'b011,
    ST_RESUME  = 3'b100
  } sleep_state_t;

  typedef struct packed {
    logic int_pin;
    logic port_b_change;
    logic [NUM_PERIPH_SRC-1:0] periph;
  } irq_vec_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
  } pin_drive_t;

endpackage : sleep_ctl_pkg

//--- sleep_wakeup_control.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - sleep clears watchdog count, stops oscillator driver
// - sleep entry clears power_down, sets timeout flag
// - pins hold pre-sleep drive state while asleep
// - wake on master clear, watchdog, or interrupt
// - master clear resets; others resume execution
// - power_down set at power-up, cleared by sleep
// - watchdog wake with no irq pending clears timeout flag
// - listed peripheral events wake the device
// - serial, usart, adc rc, eeprom also wake
// - clock-dependent peripherals silent during sleep
// - next instruction prefetched during sleep
// - wake needs source enable, ignores global enable
// - run next instruction, then vector if global enable
// - pending enabled interrupt makes sleep a no-op
// - late interrupt: finish sleep fully, then wake
module sleep_wakeup_control
  import sleep_ctl_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       NRST,
  input  wire logic       POWER_UP,
  input  wire logic       SLEEP_EXEC,
  input  wire logic       WATCHDOG_CLEAR_INSTR,
  input  wire logic [12:0] PC,
  input  wire logic       WATCHDOG_ENABLE,
  input  wire logic       WATCHDOG_TIMEOUT,
  input  wire logic       MASTER_CLEAR_PIN_N,
  input  wire logic       GLOBAL_IRQ_ENABLE,
  input  wire irq_vec_t   IRQ_FLAGS,
  input  wire irq_vec_t   IRQ_ENABLES,
  input  wire logic [NUM_PERIPH_SRC-1:0] PERIPH_ASYNC_OK,
  input  wire pin_drive_t PIN_DRIVE_IN,
  output pin_drive_t      PIN_DRIVE_OUT,
  output logic            WATCHDOG_COUNT_CLEAR,
  output logic            OSC_DRIVER_ON,
  output logic            CORE_CLK_EN,
  output logic            POWER_DOWN_FLAG,
  output logic            TIMEOUT_FLAG,
  output logic            DEVICE_RESET,
  output logic            PREFETCH_REQ,
  output logic [12:0]     PREFETCH_ADDR,
  output logic            RESUME_EXEC,
  output logic            VECTOR_REQ,
  output logic [12:0]     VECTOR_ADDR,
  output logic            SLEEPING
);

  sleep_state_t state_ff;
  sleep_state_t nxt_state;
  logic [3:0]   restart_cnt_ff;
  logic         pd_ff;
  logic         to_ff;
  logic         wdt_clr_ff;
  logic         osc_on_ff;
  logic         reset_ff;
  logic         prefetch_ff;
  logic [12:0]  prefetch_addr_ff;
  logic         resume_ff;
  logic         vector_ff;
  logic [12:0]  vector_addr_ff;
  pin_drive_t   pin_hold_ff;
  logic         irq_pending;
  logic         wd_wake;
  logic         master_clear_pin_wake;
  logic         asleep;
  logic         sleep_taken;
  logic         sleep_seen;
  logic         wd_to_clear;
  logic         restart_done;
  logic         nxt_resume;
  logic         nxt_vector;

  // asleep, a peripheral counts only when it can run without the core clock
  function automatic logic pending_irq(input irq_vec_t flg,
                                       input irq_vec_t en,
                                       input logic [NUM_PERIPH_SRC-1:0] ok,
                                       input logic in_sleep);
    logic [NUM_PERIPH_SRC-1:0] per;
    per = flg.periph & en.periph;
    if (in_sleep) begin
      per = per & ok;
    end
    pending_irq = (flg.int_pin & en.int_pin) |
                  (flg.port_b_change & en.port_b_change) |
                  (|per);
  endfunction : pending_irq

  // sleep is taken only from run and only when nothing is pending
  function automatic logic sleep_accept(input sleep_state_t cur,
                                        input sleep_state_t nxt);
    sleep_accept = (cur == ST_RUN) && (nxt == ST_ENTER);
  endfunction : sleep_accept

  // outside run the pins show the copy frozen on the last run cycle
  function automatic pin_drive_t pin_view(input sleep_state_t cur,
                                          input pin_drive_t   live,
                                          input pin_drive_t   held);
    if (cur == ST_RUN) begin
      pin_view = live;
    end else begin
      pin_view = held;
    end
  endfunction : pin_view

  assign asleep      = (state_ff == ST_ASLEEP);
  assign sleep_taken = sleep_accept(state_ff, nxt_state);
  assign sleep_seen  = SLEEP_EXEC && (state_ff == ST_RUN);
  // an irq that also wakes keeps the time-out flag set
  assign wd_to_clear = asleep && wd_wake && !irq_pending;
  assign restart_done = (restart_cnt_ff == OSC_RESTART_CYC);
  // master_clear_pin must never let a stale resume pulse escape
  assign nxt_resume  = (state_ff == ST_RESUME) && !master_clear_pin_wake;
  assign nxt_vector  = resume_ff && GLOBAL_IRQ_ENABLE && irq_pending;
  assign irq_pending = pending_irq(IRQ_FLAGS, IRQ_ENABLES,
                                   PERIPH_ASYNC_OK, asleep);
  assign wd_wake     = WATCHDOG_ENABLE & WATCHDOG_TIMEOUT;
  assign master_clear_pin_wake   = ~MASTER_CLEAR_PIN_N;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        // pending interrupt turns sleep into a no-op
        if (SLEEP_EXEC && !irq_pending) begin
          nxt_state = ST_ENTER;
        end
      end
      ST_ENTER: begin
        // side effects already done; a late irq waits until asleep, then wakes
        nxt_state = ST_ASLEEP;
      end
      ST_ASLEEP: begin
        if (irq_pending || wd_wake) begin
          nxt_state = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (restart_done) begin
          nxt_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
    if (master_clear_pin_wake) begin
      nxt_state = ST_RUN;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST || state_ff != ST_RESTART) begin
      restart_cnt_ff <= 4'h0;
    end else begin
      restart_cnt_ff <= restart_cnt_ff + 4'h1;
    end
  end

  // power_down: power-up and watchdog clear set it, sleep entry clears it
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      pd_ff <= PD_RESET_VAL;
    end else if (POWER_UP) begin
      pd_ff <= PD_RESET_VAL;
    end else if (sleep_taken) begin
      pd_ff <= 1'b0;
    end else if (WATCHDOG_CLEAR_INSTR && !wd_to_clear) begin
      pd_ff <= 1'b1;
    end
  end

  // timeout: sleep entry sets it, a pure watchdog wake clears it
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      to_ff <= TO_RESET_VAL;
    end else if (POWER_UP) begin
      to_ff <= TO_RESET_VAL;
    end else if (sleep_taken) begin
      to_ff <= 1'b1;
    end else if (wd_to_clear) begin
      to_ff <= 1'b0;
    end else if (WATCHDOG_CLEAR_INSTR) begin
      to_ff <= 1'b1;
    end
  end

  // watchdog keeps running; only its count is cleared
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      wdt_clr_ff <= 1'b0;
    end else begin
      wdt_clr_ff <= sleep_taken;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      osc_on_ff <= 1'b1;
    end else if (nxt_state == ST_ENTER) begin
      osc_on_ff <= 1'b0;
    end else if (nxt_state == ST_RESTART || nxt_state == ST_RUN) begin
      osc_on_ff <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      reset_ff <= 1'b0;
    end else begin
      reset_ff <= master_clear_pin_wake;
    end
  end

  // the prefetch pulses even for a no-op sleep, the fetch is harmless
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      prefetch_ff <= 1'b0;
    end else begin
      prefetch_ff <= sleep_seen;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      prefetch_addr_ff <= 13'h0000;
    end else if (sleep_seen) begin
      prefetch_addr_ff <= PC + PC_STEP;
    end
  end

  // resume runs the prefetched instruction, vector follows if enabled
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      resume_ff <= 1'b0;
    end else begin
      resume_ff <= nxt_resume;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      vector_ff <= 1'b0;
    end else begin
      vector_ff <= nxt_vector;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      vector_addr_ff <= 13'h0000;
    end else begin
      vector_addr_ff <= IRQ_VECTOR_ADDR;
    end
  end

  // capture only in run: the enter cycle already shows the held copy
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      pin_hold_ff <= '0;
    end else if (state_ff == ST_RUN) begin
      pin_hold_ff <= PIN_DRIVE_IN;
    end
  end

  assign PIN_DRIVE_OUT = pin_view(state_ff, PIN_DRIVE_IN,
                                  pin_hold_ff);
  assign WATCHDOG_COUNT_CLEAR = wdt_clr_ff;
  assign OSC_DRIVER_ON        = osc_on_ff;
  assign CORE_CLK_EN          = osc_on_ff && state_ff != ST_RESTART;
  assign POWER_DOWN_FLAG      = pd_ff;
  assign TIMEOUT_FLAG         = to_ff;
  assign DEVICE_RESET         = reset_ff;
  assign PREFETCH_REQ         = prefetch_ff;
  assign PREFETCH_ADDR        = prefetch_addr_ff;
  assign RESUME_EXEC          = resume_ff;
  assign VECTOR_REQ           = vector_ff;
  assign VECTOR_ADDR          = vector_addr_ff;
  assign SLEEPING             = state_ff != ST_RUN;

endmodule : sleep_wakeup_control

`default_nettype wire

//--- core_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] dly,
  input  wire logic       ack,
  output var  logic       wd_clr,
  output var  logic       sleep,
  output var  logic       irq
);
  logic [4:0] cnt_ff;
  initial begin
    {wd_clr, sleep, irq, cnt_ff} = '0;
  end
  always @(posedge clk) begin
    wd_clr <= go;
    sleep  <= wd_clr; // resume code tolerates the next word
  end
  // flag fires dly+1 cycles after go is sampled and stays up until acknowledged
  always @(posedge clk) begin
    if (go) begin
      cnt_ff <= {1'b0, dly} + 5'h01;
    end else if (cnt_ff > 5'h01) begin
      cnt_ff <= cnt_ff - 5'h01;
    end
    if (ack) begin
      irq    <= 1'b0;
      cnt_ff <= 5'h00;
    end else if (cnt_ff == 5'h01) begin
      irq <= 1'b1;
    end
  end
endmodule : core_seq_model
`default_nettype wire

//--- sleep_wakeup_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_control_chk
  import sleep_ctl_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic        SLEEP_EXEC,
  input wire logic [12:0] PC,
  input wire logic        MASTER_CLEAR_PIN_N,
  input wire logic        WATCHDOG_ENABLE,
  input wire logic        WATCHDOG_TIMEOUT,
  input wire logic        CORE_CLK_EN,
  input wire logic        DEVICE_RESET,
  input wire logic [12:0] VECTOR_ADDR,
  input wire irq_vec_t    IRQ_FLAGS,
  input wire irq_vec_t    IRQ_ENABLES,
  input wire logic [11:0] PERIPH_ASYNC_OK,
  input wire pin_drive_t  PIN_DRIVE_OUT,
  input wire logic        WATCHDOG_COUNT_CLEAR,
  input wire logic        OSC_DRIVER_ON,
  input wire logic        POWER_DOWN_FLAG,
  input wire logic        TIMEOUT_FLAG,
  input wire logic        PREFETCH_REQ,
  input wire logic [12:0] PREFETCH_ADDR,
  input wire logic        RESUME_EXEC,
  input wire logic        VECTOR_REQ,
  input wire logic        SLEEPING
);
  logic pend;
  logic wake;
  logic go;
  assign pend = |(IRQ_FLAGS & IRQ_ENABLES);
  // asleep, only sources that need no core clock may count
  assign wake = |(IRQ_FLAGS & IRQ_ENABLES & {2'b11, PERIPH_ASYNC_OK});
  assign go = SLEEP_EXEC && !SLEEPING;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  a_sleep_flags: assert property (go && !pend |=>
    !POWER_DOWN_FLAG && TIMEOUT_FLAG) else $error("sleep flags");
  a_sleep_osc: assert property (go && !pend |=>
    !OSC_DRIVER_ON && WATCHDOG_COUNT_CLEAR) else $error("sleep osc");
  a_noop_sleep: assert property (go && pend |=> !SLEEPING &&
    !WATCHDOG_COUNT_CLEAR && $stable(POWER_DOWN_FLAG)) else $error("noop");
  a_prefetch_next: assert property (go |=> PREFETCH_REQ &&
    PREFETCH_ADDR == $past(PC) + 13'h0001) else $error("prefetch");
  a_pins_hold: assert property (SLEEPING && $past(SLEEPING) |->
    $stable(PIN_DRIVE_OUT)) else $error("pins moved");
  a_master_clear_pin_wake: assert property (!MASTER_CLEAR_PIN_N |=>
    !SLEEPING && !RESUME_EXEC) else $error("master clear");
  a_wake_resume: assert property (SLEEPING && !OSC_DRIVER_ON && wake |->
    ##[3:8] RESUME_EXEC && OSC_DRIVER_ON) else $error("no resume");
  a_vector_req: assert property (VECTOR_REQ |->
    $past(RESUME_EXEC) && !SLEEPING) else $error("vector");
  a_vector_addr: assert property (VECTOR_REQ |->
    VECTOR_ADDR == IRQ_VECTOR_ADDR) else $error("vector address");
  a_reset_follow: assert property (!MASTER_CLEAR_PIN_N |=>
    DEVICE_RESET) else $error("device reset");
  a_clk_restart: assert property ($rose(OSC_DRIVER_ON) && SLEEPING |->
    !CORE_CLK_EN ##3 CORE_CLK_EN) else $error("clock restart");
  a_timeout_clear: assert property (SLEEPING && !OSC_DRIVER_ON &&
    !WATCHDOG_COUNT_CLEAR && WATCHDOG_ENABLE && WATCHDOG_TIMEOUT && !wake
    |=> !TIMEOUT_FLAG) else $error("timeout flag");
endmodule : sleep_wakeup_control_chk
bind sleep_wakeup_control sleep_wakeup_control_chk sleep_wakeup_control_chk_i (.*);
`default_nettype wire

//--- sleep_wakeup_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_control_tb
  import sleep_ctl_pkg::*;
;
  logic        CORE_CLK, NRST, SLEEP_EXEC, WATCHDOG_CLEAR_INSTR, go, ack, irq;
  logic        WATCHDOG_ENABLE, WATCHDOG_TIMEOUT, MASTER_CLEAR_PIN_N;
  logic        GLOBAL_IRQ_ENABLE, WATCHDOG_COUNT_CLEAR, OSC_DRIVER_ON;
  logic        POWER_DOWN_FLAG, TIMEOUT_FLAG, PREFETCH_REQ, RESUME_EXEC;
  logic        VECTOR_REQ, SLEEPING;
  logic [3:0]  dly;
  logic [11:0] PERIPH_ASYNC_OK;
  logic [12:0] PC;
  irq_vec_t    IRQ_FLAGS, IRQ_ENABLES;
  pin_drive_t  PIN_DRIVE_IN;
  logic [7:0]  q[$];
  int          src, seed = 88, err_count, comparisons;
  assign IRQ_FLAGS = irq_vec_t'({13'h0, irq} << src);
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  sleep_wakeup_control sleep_wakeup_control_i (.POWER_UP(1'b0),
    .PIN_DRIVE_OUT(), .CORE_CLK_EN(), .DEVICE_RESET(), .PREFETCH_ADDR(),
    .VECTOR_ADDR(), .*);
  core_seq_model core_seq_model_i (.clk(CORE_CLK), .go(go), .dly(dly),
    .ack(ack), .wd_clr(WATCHDOG_CLEAR_INSTR), .sleep(SLEEP_EXEC), .irq(irq));
  // pins change every cycle so a leaky hold shows at once
  always @(posedge CORE_CLK) PIN_DRIVE_IN <= pin_drive_t'(16'($random(seed)));
  always @(negedge CORE_CLK)
    if (NRST && (PREFETCH_REQ | RESUME_EXEC | VECTOR_REQ) === 1'b1)
      chk(q.size() != 0 ? q.pop_front() : 8'hxx, {PREFETCH_REQ,
        RESUME_EXEC, VECTOR_REQ, POWER_DOWN_FLAG, TIMEOUT_FLAG,
        OSC_DRIVER_ON, WATCHDOG_COUNT_CLEAR, SLEEPING});
  task automatic chk(input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected status: expected %h seen %h", e, s);
    end
  endtask : chk
  task results;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic trial(input logic [3:0] d, input logic w, g, e, input int s);
    logic wk;
    @(posedge CORE_CLK);
    src <= s;
    IRQ_ENABLES <= irq_vec_t'({13'h0, e} << s);
    GLOBAL_IRQ_ENABLE <= g;
    WATCHDOG_ENABLE <= w;
    dly <= d;
    go <= 1'b1;
    PERIPH_ASYNC_OK <= (d == 4'h0) ? 12'hfff : 12'($random(seed));
    PC <= 13'($random(seed));
    @(posedge CORE_CLK);
    go <= 1'b0;
    wk = d != 4'h0 && e && (s > 11 || PERIPH_ASYNC_OK[s]);
    q.push_back((d == 4'h0) ? 8'h9c : 8'h8b);
    if (wk || w) q.push_back(w ? 8'h44 : 8'h4c);
    if (wk && g && !w) q.push_back(8'h2c);
    repeat (6) @(posedge CORE_CLK);
    WATCHDOG_TIMEOUT <= w;
    @(posedge CORE_CLK);
    WATCHDOG_TIMEOUT <= 1'b0;
    repeat (30) @(posedge CORE_CLK);
    if (!(wk || w) && d != 4'h0) MASTER_CLEAR_PIN_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    MASTER_CLEAR_PIN_N <= 1'b1;
    ack <= 1'b1;
    @(posedge CORE_CLK);
    ack <= 1'b0;
  endtask : trial
  initial begin
    {NRST, go, ack, WATCHDOG_TIMEOUT, GLOBAL_IRQ_ENABLE, WATCHDOG_ENABLE} = '0;
    {dly, src, PERIPH_ASYNC_OK, IRQ_ENABLES, PC, PIN_DRIVE_IN} = '0;
    MASTER_CLEAR_PIN_N = 1'b1;
    repeat (3) @(posedge CORE_CLK);
    NRST <= 1'b1;
    trial(4'h0, 1'b0, 1'b1, 1'b1, 13);
    trial(4'h1, 1'b0, 1'b0, 1'b1, 12);
    trial(4'h5, 1'b0, 1'b1, 1'b1, 3);
    trial(4'hf, 1'b1, 1'b0, 1'b0, 0);
    trial(4'h4, 1'b0, 1'b1, 1'b0, 13);
    repeat (12) trial(4'($random(seed)) | 4'h1, 1'b0, 1'($random(seed)),
      1'b1, $unsigned($random(seed)) % 14);
    repeat (5) @(posedge CORE_CLK);
    chk(8'h00, 8'(q.size()));
    results();
  end
  // 17 trials of 42 cycles each fit well inside this span
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    err_count++;
    results();
  end
endmodule : sleep_wakeup_control_tb
`default_nettype wire
